// [rtl/ptic_top.sv]
/*
 what: port direction, pull and open-drain control, interrupt enables and
 flags, option register, prescaler and Timer0 of a small controller.
 assumes: ref_clk is the instruction clock; register strobes are one-cycle
 pulses from the core; pin levels are resolved outside from out/oe.
*/
module ptic_top (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // register access from the core
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // instruction strobes
    input wire logic [7:0] accumulator,
    input wire logic option_load,
    input wire logic direction_load_instr,
    input wire logic [7:0] direction_operand,
    input wire logic return_from_irq_instr,
    input wire logic sleeping,
    // configuration and neighbouring control bits
    input wire logic ext_irq_pin_select,
    input wire logic pin3_open_drain_cfg,
    input wire logic [3:0] alt_func_a,
    input wire logic [7:0] alt_func_b,
    input wire logic [3:0] pull_down_disable_a,
    input wire logic [2:0] pull_down_disable_b,
    // watchdog side of the prescaler
    input wire logic wdt_tick,
    output logic wdt_scaled_tick,
    // port pins
    input wire logic [3:0] port_a_in,
    output logic [3:0] port_a_out,
    output logic [3:0] port_a_oe,
    input wire logic [7:0] port_b_in,
    output logic [7:0] port_b_out,
    output logic [7:0] port_b_oe,
    output logic [7:0] pull_high_en_b,
    output logic [3:0] pull_down_en_a,
    output logic [2:0] pull_down_en_b,
    // interrupt to the core
    output logic irq_vector_req,
    output logic wake_resume_next,
    output logic irq_pending
);

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] pull_high_control;
    logic [7:0] interrupt_mask;
    logic [7:0] interrupt_flags;
    logic [7:0] timer_prescaler_options;
    logic [7:0] port_a_direction;
    logic [7:0] port_b_direction;
    logic [7:0] wake_change_enable;
    logic [7:0] port_a_latch;
    logic [7:0] port_b_latch;
    logic [7:0] timer_count;
    logic [7:0] prescaler;
    logic [1:0] inhibit_cnt;

    // synchronisers: stage one feeds stage two only
    logic [7:0] b_meta;
    logic [7:0] b_sync;
    logic [7:0] b_prev;
    logic [3:0] a_meta;
    logic [3:0] a_sync;

    // decoded option fields
    logic edge_sel;
    logic clk_source;
    logic src_edge;
    logic assign_wdt;
    logic [2:0] rate;
    assign edge_sel = timer_prescaler_options[ptic_pkg::OPT_EDGE_SEL_BIT];
    assign clk_source = timer_prescaler_options[ptic_pkg::OPT_CLK_SRC_BIT];
    assign src_edge = timer_prescaler_options[ptic_pkg::OPT_SRC_EDGE_BIT];
    assign assign_wdt = timer_prescaler_options[ptic_pkg::OPT_ASSIGN_BIT];
    assign rate = timer_prescaler_options[ptic_pkg::OPT_RATE_MSB:0];

    logic global_irq_enable;
    assign global_irq_enable = interrupt_mask[ptic_pkg::GLOBAL_EN_BIT];

    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] which);
        reg_hit = (addr == which);
    endfunction

    // low bits that must all be ones for one prescaled tick
    function automatic logic [7:0] rate_mask(input logic [2:0] r, input logic extra);
        logic [8:0] m;
        m = ({1'b0, 8'h01} << (9'(r) + 9'(extra))) - 9'h001;
        rate_mask = m[7:0];
    endfunction

    logic tmr_wr;
    assign tmr_wr = reg_wr && reg_hit(reg_addr, ptic_pkg::TIMER_COUNT_ADDR);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            b_meta <= 8'h00;
            b_sync <= 8'h00;
            b_prev <= 8'h00;
            a_meta <= 4'h0;
            a_sync <= 4'h0;
        end else begin
            b_meta <= port_b_in;
            b_sync <= b_meta;
            b_prev <= b_sync;
            a_meta <= port_a_in;
            a_sync <= a_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // option and direction loads
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            timer_prescaler_options <= ptic_pkg::OPTION_RESET;
        end else if (option_load) begin
            timer_prescaler_options <= accumulator;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            port_a_direction <= ptic_pkg::DIR_RESET;
            port_b_direction <= ptic_pkg::DIR_RESET;
        end else if (direction_load_instr) begin
            if (direction_operand == ptic_pkg::PORT_A_ADDR) begin
                port_a_direction <= accumulator;
            end
            if (direction_operand == ptic_pkg::PORT_B_ADDR) begin
                port_b_direction <= accumulator;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write registers; pull-high and wake enable also read back
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pull_high_control <= ptic_pkg::PULL_HIGH_RESET;
            wake_change_enable <= ptic_pkg::WAKE_CHANGE_RESET;
            port_a_latch <= 8'h00;
            port_b_latch <= 8'h00;
        end else if (reg_wr) begin
            if (reg_hit(reg_addr, ptic_pkg::PULL_HIGH_ADDR)) begin
                pull_high_control <= reg_wdata;
            end
            if (reg_hit(reg_addr, ptic_pkg::WAKE_CHANGE_ADDR)) begin
                wake_change_enable <= reg_wdata;
            end
            if (reg_hit(reg_addr, ptic_pkg::PORT_A_ADDR)) begin
                port_a_latch <= reg_wdata;
            end
            if (reg_hit(reg_addr, ptic_pkg::PORT_B_ADDR)) begin
                port_b_latch <= reg_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drivers and pulls
    logic [7:0] eff_dir_b;
    always_comb begin
        eff_dir_b = port_b_direction;
        eff_dir_b[ptic_pkg::EXT_CLK_PIN_BIT] = port_b_direction[ptic_pkg::EXT_CLK_PIN_BIT]
            | clk_source;
    end

    assign port_a_out = port_a_latch[3:0];
    assign port_a_oe = ~port_a_direction[3:0];

    always_comb begin
        port_b_out = port_b_latch;
        port_b_oe = ~eff_dir_b;
        // pin3 only ever pulls low, and only if pin3_open_drain_cfg allows it
        port_b_out[ptic_pkg::OD_PIN_BIT] = 1'b0;
        port_b_oe[ptic_pkg::OD_PIN_BIT] = ~eff_dir_b[ptic_pkg::OD_PIN_BIT]
            & pin3_open_drain_cfg & ~port_b_latch[ptic_pkg::OD_PIN_BIT];
    end

    always_comb begin
        pull_high_en_b = ~pull_high_control & eff_dir_b;
        pull_high_en_b[ptic_pkg::PULL_HIGH_GP_BIT] = 1'b0;
    end
    assign pull_down_en_a = ~pull_down_disable_a & port_a_direction[3:0];
    assign pull_down_en_b = ~pull_down_disable_b & eff_dir_b[2:0];

    ////////////////////////////////////////////////////////////////////////
    // event detection
    logic [7:0] change_en;
    logic portb_change;
    logic ext_level;
    logic ext_last;
    logic ext_edge;
    always_comb begin
        change_en = wake_change_enable & eff_dir_b;
        if (ext_irq_pin_select) begin
            change_en[ptic_pkg::EXT_IRQ_PIN_BIT] = 1'b0;
        end
    end
    assign portb_change = |((b_sync ^ b_prev) & change_en);
    assign ext_level = b_sync[ptic_pkg::EXT_IRQ_PIN_BIT];
    assign ext_last = b_prev[ptic_pkg::EXT_IRQ_PIN_BIT];
    assign ext_edge = ext_irq_pin_select
        && (edge_sel ? (ext_level && !ext_last) : (!ext_level && ext_last));

    ////////////////////////////////////////////////////////////////////////
    // prescaler and Timer0
    logic tck_now;
    logic tck_last;
    logic ext_clk_edge;
    logic src_tick;
    logic pre_in;
    logic pre_out;
    logic timer_inc;
    logic timer_ovf;
    assign tck_now = b_sync[ptic_pkg::EXT_CLK_PIN_BIT];
    assign tck_last = b_prev[ptic_pkg::EXT_CLK_PIN_BIT];
    assign ext_clk_edge = src_edge ? (!tck_now && tck_last) : (tck_now && !tck_last);
    assign src_tick = clk_source ? ext_clk_edge : 1'b1;
    assign pre_in = assign_wdt ? wdt_tick : src_tick;
    assign pre_out = pre_in
        && ((prescaler & rate_mask(rate, !assign_wdt)) == rate_mask(rate, !assign_wdt));
    assign timer_inc = (assign_wdt ? src_tick : pre_out)
        && inhibit_cnt == 2'd0 && !tmr_wr;
    assign timer_ovf = timer_inc && timer_count == 8'hff;
    assign wdt_scaled_tick = assign_wdt && pre_out;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            prescaler <= ptic_pkg::PRESCALER_RESET;
        end else if (tmr_wr && !assign_wdt) begin
            prescaler <= 8'h00;
        end else if (pre_in) begin
            prescaler <= prescaler + 8'h01;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            timer_count <= 8'h00;
            inhibit_cnt <= 2'd0;
        end else if (tmr_wr) begin
            timer_count <= reg_wdata;
            inhibit_cnt <= ptic_pkg::WRITE_INHIBIT_CYCLES;
        end else begin
            if (inhibit_cnt != 2'd0) begin
                inhibit_cnt <= inhibit_cnt - 2'd1;
            end
            if (timer_inc) begin
                timer_count <= timer_count + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt flags: a hardware set wins over a software clear
    logic [2:0] flag_set;
    logic [2:0] flag_wr_val;
    logic flags_wr;
    assign flag_set = {ext_edge, portb_change, timer_ovf};
    assign flags_wr = reg_wr && reg_hit(reg_addr, ptic_pkg::IRQ_FLAGS_ADDR);
    assign flag_wr_val = flags_wr ? reg_wdata[2:0] : interrupt_flags[2:0];

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            interrupt_flags <= 8'h00;
        end else begin
            interrupt_flags <= {5'h00, flag_wr_val | flag_set};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // enables, global enable and vectoring
    logic pending;
    logic take_irq;
    logic wake;
    assign pending = |(interrupt_flags[2:0] & interrupt_mask[2:0]);
    assign take_irq = global_irq_enable && pending && !return_from_irq_instr;
    assign wake = sleeping && pending;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            interrupt_mask <= ptic_pkg::MASK_RESET;
        end else begin
            if (reg_wr && reg_hit(reg_addr, ptic_pkg::IRQ_MASK_ADDR)) begin
                interrupt_mask <= reg_wdata & ~ptic_pkg::MASK_UNUSED_ONES;
            end
            if (return_from_irq_instr) begin
                interrupt_mask[ptic_pkg::GLOBAL_EN_BIT] <= 1'b1;
            end else if (take_irq) begin
                interrupt_mask[ptic_pkg::GLOBAL_EN_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            irq_vector_req <= 1'b0;
            wake_resume_next <= 1'b0;
            irq_pending <= 1'b0;
        end else begin
            irq_vector_req <= take_irq;
            wake_resume_next <= wake && !global_irq_enable;
            irq_pending <= pending;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register reads
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                ptic_pkg::TIMER_COUNT_ADDR: reg_rdata <= timer_count;
                ptic_pkg::PORT_A_ADDR:
                    reg_rdata <= {port_a_latch[7:4], a_sync & ~alt_func_a};
                ptic_pkg::PORT_B_ADDR: reg_rdata <= b_sync & ~alt_func_b;
                ptic_pkg::WAKE_CHANGE_ADDR: reg_rdata <= wake_change_enable;
                ptic_pkg::PULL_HIGH_ADDR: reg_rdata <= pull_high_control;
                ptic_pkg::IRQ_MASK_ADDR:
                    reg_rdata <= interrupt_mask | ptic_pkg::MASK_UNUSED_ONES;
                ptic_pkg::IRQ_FLAGS_ADDR:
                    reg_rdata <= interrupt_flags & ptic_pkg::FLAG_USED_BITS;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    ovf_flag_set_a: assert property (
        timer_ovf |=> interrupt_flags[0] && timer_count == 8'h00)
        else $error("overflow did not set flag");
    write_inhibit_a: assert property (
        tmr_wr ##1 !tmr_wr ##1 !tmr_wr |=> timer_count == $past(reg_wdata, 3))
        else $error("timer counted during write inhibit");
    global_en_clear_a: assert property (
        global_irq_enable && pending && !return_from_irq_instr
        |=> !global_irq_enable && irq_vector_req)
        else $error("global enable not cleared on interrupt");
    irq_return_a: assert property (
        return_from_irq_instr |=> global_irq_enable)
        else $error("return did not set global enable");
    option_load_a: assert property (
        option_load |=> timer_prescaler_options == $past(accumulator))
        else $error("option not loaded from accumulator");
    pin3_drive_a: assert property (
        port_b_oe[3] |-> !port_b_direction[3] && pin3_open_drain_cfg && !port_b_out[3])
        else $error("pin3 driven outside open drain");
    pull_off_a: assert property (
        ((pull_high_en_b & ~eff_dir_b) == 8'h00)
        && ((pull_down_en_b & ~eff_dir_b[2:0]) == 3'h0))
        else $error("pull active on output pin");
    pin2_input_a: assert property (
        clk_source |-> !port_b_oe[2])
        else $error("pin2 driven in counter mode");
    flag_read_a: assert property (
        reg_rd && reg_addr == ptic_pkg::IRQ_FLAGS_ADDR |=> reg_rdata[7:3] == 5'h00)
        else $error("flag upper bits not zero");
    ext_flag_a: assert property (
        ext_edge |=> interrupt_flags[2])
        else $error("external edge lost");
    b0_masked_a: assert property (
        ext_irq_pin_select && (b_sync ^ b_prev) == 8'h01 |-> !portb_change)
        else $error("pin0 change seen as interrupt pin");

    ovf_seen_c: cover property (timer_ovf ##1 irq_vector_req);
    change_seen_c: cover property (portb_change ##1 interrupt_flags[1]);
    wake_resume_c: cover property (wake && !global_irq_enable ##1 wake_resume_next);
    ext_count_c: cover property (clk_source && timer_inc);

endmodule

// [rtl/ptic_pkg.sv]
/*
 what: constants for the port, interrupt and timer control block.
 assumes: the core presents register accesses, accumulator loads and
 instruction strobes on the instruction clock.
*/
// What this block does
// - pull-high bits active low, bit3 plain storage
// - mask holds three enables, bits6-3 read ones
// - enable one passes source, zero blocks it
// - wake with global enable branches, else resumes
// - taken interrupt clears global enable; return sets
// - timer overflow flag bit0; bits7-3 read zero
// - port B change flag bit1 until cleared
// - external pin flag bit2 on selected edge
// - option write-only, loaded from accumulator, reset BFh (bit6 zero)
// - rate bits divide timer 2-256, watchdog 1-128
// - assign bit zero timer, one watchdog
// - counter mode edge: zero rising, one falling
// - clock source external forces pin2 to input
// - edge select zero falling, one rising
// - direction registers write-only, reset all inputs
// - direction one input, zero output
// - pin3 open drain only, config can disable
// - pull-high and pull-down off for outputs
// - pin0 as interrupt input loses change detect
// - alternate function pins read as zero
// - timer increments per cycle, write inhibits two
// - overflow flag set on FFh to 00h wrap
// - change detect skips disabled, output, interrupt pins
// - wake enable register, one bit per pin
package ptic_pkg;
    localparam logic [7:0] TIMER_COUNT_ADDR = 8'h01;
    localparam logic [7:0] PORT_A_ADDR = 8'h05;
    localparam logic [7:0] PORT_B_ADDR = 8'h06;
    localparam logic [7:0] WAKE_CHANGE_ADDR = 8'h09;
    localparam logic [7:0] PULL_HIGH_ADDR = 8'h0d;
    localparam logic [7:0] IRQ_MASK_ADDR = 8'h0e;
    localparam logic [7:0] IRQ_FLAGS_ADDR = 8'h0f;

    localparam int FLAG_TIMER_BIT = 0;
    localparam int FLAG_PORTB_BIT = 1;
    localparam int FLAG_EXT_BIT = 2;
    localparam int GLOBAL_EN_BIT = 7;
    localparam int PULL_HIGH_GP_BIT = 3;
    localparam int OD_PIN_BIT = 3;
    localparam int EXT_CLK_PIN_BIT = 2;
    localparam int EXT_IRQ_PIN_BIT = 0;

    localparam int OPT_EDGE_SEL_BIT = 6;
    localparam int OPT_CLK_SRC_BIT = 5;
    localparam int OPT_SRC_EDGE_BIT = 4;
    localparam int OPT_ASSIGN_BIT = 3;
    localparam int OPT_RATE_MSB = 2;

    localparam logic [7:0] MASK_UNUSED_ONES = 8'h78;
    localparam logic [7:0] FLAG_USED_BITS = 8'h07;
    localparam logic [7:0] OPTION_RESET = 8'hbf;
    localparam logic [7:0] DIR_RESET = 8'hff;
    localparam logic [7:0] PULL_HIGH_RESET = 8'hff;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] WAKE_CHANGE_RESET = 8'h00;
    localparam logic [7:0] PRESCALER_RESET = 8'hff;
    localparam logic [1:0] WRITE_INHIBIT_CYCLES = 2'd2;
endpackage

// [tb/ptic_pins.sv]
/*
 what: pin model for the port block; resolves each pin level from the
 block's drivers, the bench's outside levels and the weak pull-downs.
 assumes: the bench drives ext_val for port B; port A has no outside driver.
*/
module ptic_pins (
    // clock
    input wire logic ref_clk,
    // port A side
    input wire logic [3:0] port_a_out,
    input wire logic [3:0] port_a_oe,
    input wire logic [3:0] pull_down_en_a,
    output logic [3:0] port_a_in,
    // port B side
    input wire logic [7:0] port_b_out,
    input wire logic [7:0] port_b_oe,
    input wire logic [7:0] ext_val,
    output logic [7:0] port_b_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic flt;
    initial flt = 1'b0;
    // an undriven pin without a pull wanders every cycle
    always @(posedge ref_clk) flt <= ~flt;
    assign port_a_in = (port_a_oe & port_a_out) | (~port_a_oe & ~pull_down_en_a & {4{flt}});
    // the block wins where it drives; pin 3 only ever pulls low
    assign port_b_in = (port_b_oe & port_b_out) | (~port_b_oe & ext_val);
endmodule

// [tb/port_timer_interrupt_ctrl_test.sv]
/*
 what: self-checking bench for the port, interrupt and timer block.
 assumes: ptic_pkg, ptic_top and ptic_pins are compiled before it.
*/
module port_timer_interrupt_ctrl_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk, sys_rst, reg_wr, reg_rd, option_load, direction_load_instr;
    logic return_from_irq_instr, sleeping, ext_irq_pin_select, pin3_open_drain_cfg;
    logic wdt_tick, wdt_scaled_tick, irq_vector_req, wake_resume_next, irq_pending;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, accumulator, direction_operand, alt_func_b;
    logic [7:0] port_b_in, port_b_out, port_b_oe, pull_high_en_b, ext_val, v0, v1;
    logic [3:0] alt_func_a, pull_down_disable_a, port_a_in, port_a_out, port_a_oe;
    logic [3:0] pull_down_en_a;
    logic [2:0] pull_down_disable_b, pull_down_en_b;
    int num_errors, checks, n;
    ////////////////////////////////////////////////////////////
    ptic_top DUT (
        .ref_clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .accumulator, .option_load, .direction_load_instr, .direction_operand,
        .return_from_irq_instr, .sleeping, .ext_irq_pin_select, .pin3_open_drain_cfg,
        .alt_func_a, .alt_func_b, .pull_down_disable_a, .pull_down_disable_b, .wdt_tick,
        .wdt_scaled_tick, .port_a_in, .port_a_out, .port_a_oe, .port_b_in, .port_b_out,
        .port_b_oe, .pull_high_en_b, .pull_down_en_a, .pull_down_en_b, .irq_vector_req,
        .wake_resume_next, .irq_pending
    );
    ptic_pins pins (
        .ref_clk, .port_a_out, .port_a_oe, .pull_down_en_a, .port_a_in,
        .port_b_out, .port_b_oe, .ext_val, .port_b_in
    );
    ////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        cyc(1);
        reg_wr = 1'b0;
        cyc(1);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        reg_addr = a;
        reg_rd = 1'b1;
        cyc(1);
        reg_rd = 1'b0;
        v = reg_rdata;
        cyc(1);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        check($sformatf("reg %h", a), v, exp);
    endtask
    task automatic opt(input logic [7:0] a);
        accumulator = a;
        option_load = 1'b1;
        cyc(1);
        option_load = 1'b0;
        cyc(1);
    endtask
    task automatic dirld(input logic [7:0] op, input logic [7:0] a);
        accumulator = a;
        direction_operand = op;
        direction_load_instr = 1'b1;
        cyc(1);
        direction_load_instr = 1'b0;
        cyc(1);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic test_pins;
        check("oe_a", {4'h0, port_a_oe}, 8'h00);
        check("oe_b", port_b_oe, 8'h00);
        check("ph_b", pull_high_en_b, 8'h00);
        check("pd", {1'b0, pull_down_en_b, pull_down_en_a}, 8'h7f);
        rdc(ptic_pkg::IRQ_MASK_ADDR, 8'h78);
        rdc(ptic_pkg::IRQ_FLAGS_ADDR, 8'h00);
        wr(ptic_pkg::PULL_HIGH_ADDR, 8'h08);
        check("ph_b", pull_high_en_b, 8'hf7);
        rdc(ptic_pkg::PULL_HIGH_ADDR, 8'h08);
        dirld(8'h05, 8'h00);
        check("oe_a", {4'h0, port_a_oe}, 8'h0f);
        check("pd_a", {4'h0, pull_down_en_a}, 8'h00);
        wr(ptic_pkg::PORT_A_ADDR, 8'ha5);
        cyc(1);
        rdc(ptic_pkg::PORT_A_ADDR, 8'ha5);
        alt_func_a = 4'h1;
        rdc(ptic_pkg::PORT_A_ADDR, 8'ha4);
        alt_func_a = 4'h0;
        wr(ptic_pkg::PORT_B_ADDR, 8'h00);
        dirld(8'h06, 8'h00);
        check("oe_b", port_b_oe, 8'hfb);
        check("ph_b", pull_high_en_b, 8'h04);
        pin3_open_drain_cfg = 1'b0;
        cyc(1);
        check("oe_b", port_b_oe, 8'hf3);
        pin3_open_drain_cfg = 1'b1;
        opt(8'h08);
        check("oe_b", port_b_oe, 8'hff);
        dirld(8'h07, 8'h0f);
        check("oe_b", port_b_oe, 8'hff);
        dirld(8'h06, 8'hff);
        check("oe_b", port_b_oe, 8'h00);
    endtask
    task automatic test_timer_irq;
        logic [7:0] tseq [4] = '{8'hfe, 8'hfe, 8'hff, 8'h00};
        wr(ptic_pkg::TIMER_COUNT_ADDR, 8'hfe);
        reg_addr = ptic_pkg::TIMER_COUNT_ADDR;
        reg_rd = 1'b1;
        foreach (tseq[i]) begin
            cyc(1);
            check("timer", reg_rdata, tseq[i]);
        end
        reg_rd = 1'b0;
        cyc(1);
        rdc(ptic_pkg::IRQ_FLAGS_ADDR, 8'h01);
        wr(ptic_pkg::IRQ_MASK_ADDR, 8'h80);
        cyc(3);
        check("pending", {7'h0, irq_pending}, 8'h00);
        wr(ptic_pkg::IRQ_MASK_ADDR, 8'h81);
        for (n = 0; n < 20 && irq_vector_req !== 1'b1; n++) begin
            cyc(1);
        end
        check("irq_taken", 8'(n < 20), 8'h01);
        if (n == 20) begin
            print_verdict();
        end
        cyc(1);
        check("irq_req", {7'h0, irq_vector_req}, 8'h00);
        rdc(ptic_pkg::IRQ_MASK_ADDR, 8'h79);
        sleeping = 1'b1;
        cyc(2);
        check("resume", {7'h0, wake_resume_next}, 8'h01);
        sleeping = 1'b0;
        opt(8'h28);
        wr(ptic_pkg::IRQ_FLAGS_ADDR, 8'h00);
        return_from_irq_instr = 1'b1;
        cyc(1);
        return_from_irq_instr = 1'b0;
        cyc(1);
        rdc(ptic_pkg::IRQ_MASK_ADDR, 8'hf9);
        wr(ptic_pkg::IRQ_MASK_ADDR, 8'h00);
    endtask
    task automatic test_ext_change;
        ext_irq_pin_select = 1'b1;
        wr(ptic_pkg::WAKE_CHANGE_ADDR, 8'h01);
        for (int es = 0; es < 2; es++) begin
            opt(es == 1 ? 8'h68 : 8'h28);
            wr(ptic_pkg::IRQ_FLAGS_ADDR, 8'h00);
            ext_val[0] = (es == 0);
            cyc(6);
            rdc(ptic_pkg::IRQ_FLAGS_ADDR, 8'h00);
            ext_val[0] = (es == 1);
            cyc(6);
            rdc(ptic_pkg::IRQ_FLAGS_ADDR, 8'h04);
        end
        ext_irq_pin_select = 1'b0;
        wr(ptic_pkg::PORT_B_ADDR, 8'h20);
        dirld(8'h06, 8'hdf);
        wr(ptic_pkg::WAKE_CHANGE_ADDR, 8'h23);
        wr(ptic_pkg::IRQ_FLAGS_ADDR, 8'h00);
        ext_val[6] = 1'b1;
        cyc(6);
        rdc(ptic_pkg::IRQ_FLAGS_ADDR, 8'h00);
        ext_val[1] = 1'b1;
        cyc(6);
        rdc(ptic_pkg::IRQ_FLAGS_ADDR, 8'h02);
        alt_func_b = 8'h02;
        rdc(ptic_pkg::PORT_B_ADDR, 8'h61);
        alt_func_b = 8'h00;
        wr(ptic_pkg::WAKE_CHANGE_ADDR, 8'h00);
        dirld(8'h06, 8'hff);
    endtask
    task automatic test_counter;
        for (int se = 0; se < 2; se++) begin
            ext_val[2] = 1'b0;
            opt(se == 1 ? 8'h38 : 8'h28);
            cyc(4);
            wr(ptic_pkg::TIMER_COUNT_ADDR, 8'h00);
            ext_val[2] = 1'b1;
            cyc(6);
            rdc(ptic_pkg::TIMER_COUNT_ADDR, se == 1 ? 8'h00 : 8'h01);
            ext_val[2] = 1'b0;
            cyc(6);
            rdc(ptic_pkg::TIMER_COUNT_ADDR, 8'h01);
        end
    endtask
    task automatic test_prescale;
        for (int r = 0; r < 4; r++) begin
            opt(8'(r));
            rd(ptic_pkg::TIMER_COUNT_ADDR, v0);
            cyc(30);
            rd(ptic_pkg::TIMER_COUNT_ADDR, v1);
            check("timer_steps", v1 - v0, 8'h10 >> r);
            opt(8'h08 | 8'(r));
            wdt_tick = 1'b1;
            n = 0;
            repeat (16) begin
                #1;
                n += int'(wdt_scaled_tick === 1'b1);
                cyc(1);
            end
            wdt_tick = 1'b0;
            check("wdt_ticks", 8'(n), 8'h10 >> r);
        end
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial begin
        num_errors = 0;
        checks = 0;
        {reg_wr, reg_rd, option_load, direction_load_instr, return_from_irq_instr} = '0;
        {sleeping, ext_irq_pin_select, wdt_tick} = '0;
        pin3_open_drain_cfg = 1'b1;
        {reg_addr, reg_wdata, accumulator, direction_operand, alt_func_b, ext_val} = '0;
        {alt_func_a, pull_down_disable_a, pull_down_disable_b} = '0;
        sys_rst = 1'b1;
        repeat (10) @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
        test_pins();
        test_timer_irq();
        test_ext_change();
        test_counter();
        test_prescale();
        print_verdict();
    end
endmodule
